// ---- design/tx_cfg_pkg.sv ----
// Shared constants and types for the transmitter configuration block
package tx_cfg_pkg;

  // Register byte addresses
  localparam logic [7:0] MOD_CFG_ADDR = 8'h00;
  localparam logic [7:0] POST_DIV_ADDR = 8'h01;
  localparam logic [7:0] PRE_DIV_ADDR = 8'h02;
  localparam logic [7:0] PA_LEVEL_ADDR = 8'h06;
  localparam logic [7:0] CARRIER_A_ADDR = 8'h0b;
  localparam logic [7:0] CARRIER_B_ADDR = 8'h0c;
  localparam logic [7:0] CARRIER_C_ADDR = 8'h0d;
  localparam logic [7:0] FSK_DEV_ADDR = 8'h0e;
  localparam logic [7:0] TX_DATA_ADDR = 8'h10;
  localparam logic [7:0] TX_STATUS_ADDR = 8'h11;

  // Field layout
  localparam int MOD_SEL_BIT = 0;
  localparam int PA_W = 3;
  localparam int POST_W = 3;
  localparam int DEV_W = 7;
  localparam int CARRIER_W = 24;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_UNDERFLOW_BIT = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int STAT_FULL_BIT = 3;
  localparam logic MOD_FSK = 1'b1;
  localparam int DEV_SHIFT = 3; // One deviation step is eight carrier steps

  // Reset values and legal divider ranges
  localparam logic MOD_RESET = 1'b0;
  localparam logic [PA_W-1:0] PA_RESET = 3'h0;
  localparam logic [POST_W-1:0] POST_RESET = 3'h1;
  localparam logic [7:0] PRE_RESET = 8'h03;
  localparam logic [CARRIER_W-1:0] CARRIER_RESET = 24'h000000;
  localparam logic [DEV_W-1:0] DEV_RESET = 7'h00;
  localparam logic [POST_W-1:0] POST_MIN = 3'h1;
  localparam logic [POST_W-1:0] POST_MAX = 3'h5;
  localparam logic [7:0] PRE_MIN = 8'h03;

  // Serial bus bit slots
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Timing
  localparam int CLK_HZ = 200_000_000;
  localparam int XTAL_HZ = 16_000_000;
  localparam int XTAL_DIV_RATIO = 5;
  localparam int PRESET_CLK_HZ = 800_000;
  localparam int PRESET_HALF_CYCLES = CLK_HZ / (2 * PRESET_CLK_HZ);

  typedef enum {
    st_idle, st_addr, st_pointer, st_write, st_read
  } bus_state_e;

endpackage : tx_cfg_pkg

// ---- design/stream_if.sv ----
// Valid/ready byte stream between the register logic and the buffer
interface stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface : stream_if

// ---- design/byte_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  stream_if.sink push,
  stream_if.source pop
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  // Full and empty come straight from the occupancy count
  assign push.ready = (count != FULL_COUNT);
  assign pop.valid = (count != '0);
  assign pop.data = mem[rd_ptr];
  assign do_push = push.valid && push.ready;
  assign do_pop = pop.valid && pop.ready;

  // One storage word per entry, written when the pointer selects it
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        mem[i] <= '0;
      end else if (do_push && wr_ptr == AW'(i)) begin
        mem[i] <= push.data;
      end
    end
  end

  // Pointers wrap explicitly so a depth that is not a power of two works
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
      if (do_push && !do_pop) count <= count + 1'b1;
      else if (do_pop && !do_push) count <= count - 1'b1;
    end
  end

  property p_no_push_when_full;
    @(posedge clk) disable iff (!rstn)
      (count == FULL_COUNT && !pop.ready) |=> !push.ready;
  endproperty
  a_no_push_when_full: assert property (p_no_push_when_full)
    else $error("fifo accepts data while full");

  property p_push_shows_valid;
    @(posedge clk) disable iff (!rstn)
      (do_push && !pop.valid) |=> pop.valid;
  endproperty
  a_push_shows_valid: assert property (p_push_shows_valid)
    else $error("pushed word not visible at output");

endmodule : byte_fifo

// ---- design/tx_config_regs_baud_divider.sv ----
// Transmitter configuration registers, serial bus slave and baud divider
//
// Function
// - Bus mode: data pin is serial data
// - Bus mode: clock pin is serial clock input
// - Both select pins low selects bus mode
// - Config bit 0 selects ASK or FSK
// - Three-bit amplifier level sets output power
// - Amplifier level resets to lowest code
// - 24-bit carrier word over three registers
// - 7-bit deviation field sets FSK offset
// - Space at carrier, mark at carrier plus deviation
// - Baud equals clock over pre times post
// - Divider clock is crystal over fixed ratio
// - Divider fields limited to legal ranges
// - Preset mode drives 800kHz on clock pin
// - Empty buffer in bus mode ends transmission
module tx_config_regs_baud_divider
  import tx_cfg_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h2a, // Arbitrary bus address
  parameter int FIFO_DEPTH = 8,
  parameter int XTAL_DIV = XTAL_DIV_RATIO
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tx_data_input_in,
  output logic tx_data_input_out,
  output logic tx_data_input_oe,
  input wire logic clock_output_pin_in,
  output logic clock_output_pin_out,
  output logic clock_output_pin_oe,
  input wire logic preset_select_low,
  input wire logic preset_select_high,
  output logic i2c_mode,
  output logic [1:0] preset_code,
  output logic modulation_select,
  output logic [PA_W-1:0] amp_power_level,
  output logic [CARRIER_W-1:0] carrier_word,
  output logic [DEV_W-1:0] fsk_offset_field,
  output logic tx_enable,
  output logic tx_symbol,
  output logic [CARRIER_W-1:0] synth_word,
  output logic baud_strobe
);
  localparam logic [3:0] XDIV_LAST = 4'(XTAL_DIV - 1);
  localparam logic [7:0] HALF_LAST = 8'(PRESET_HALF_CYCLES - 1);
  localparam int ACC_W = 28;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(XTAL_HZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);

  logic [1:0] sel_low_q, sel_high_q, sda_q, scl_q;
  logic sda_d, scl_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  bus_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift, tx_shift, reg_ptr, rd_val;
  logic sda_drive;
  logic wr_en;
  logic [7:0] wr_addr, wr_data;
  logic [POST_W-1:0] post_div;
  logic [7:0] pre_div;
  logic [POST_W-1:0] eff_post;
  logic [7:0] eff_pre;
  logic [6:0] post_last;
  logic div_reload;
  logic [ACC_W-1:0] xtal_acc;
  logic xtal_tick, bclk_tick;
  logic [3:0] xdiv_cnt;
  logic [7:0] pre_cnt;
  logic [6:0] post_cnt;
  logic [7:0] half_cnt;
  logic preset_clk;
  logic tx_active, underflow;
  logic [3:0] bits_left;
  logic [7:0] tx_byte;
  logic sym_bit;
  logic [CARRIER_W-1:0] mark_word;

  stream_if #(.WIDTH(8)) push_if ();
  stream_if #(.WIDTH(8)) pop_if ();

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .push(push_if.sink),
    .pop(pop_if.source)
  );

  // Pins from outside pass two flops before anything looks at them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_low_q <= '0;
      sel_high_q <= '0;
      sda_q <= '0;
      scl_q <= '0;
      sda_d <= 1'b0;
      scl_d <= 1'b0;
    end else begin
      sel_low_q <= {sel_low_q[0], preset_select_low};
      sel_high_q <= {sel_high_q[0], preset_select_high};
      sda_q <= {sda_q[0], tx_data_input_in};
      scl_q <= {scl_q[0], clock_output_pin_in};
      sda_d <= sda_q[1];
      scl_d <= scl_q[1];
    end
  end

  // Mode selection from the preset pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      i2c_mode <= 1'b0;
      preset_code <= '0;
    end else begin
      i2c_mode <= ~sel_low_q[1] & ~sel_high_q[1];
      preset_code <= {sel_high_q[1], sel_low_q[1]};
    end
  end

  // Bus events only count in bus mode; in preset mode the data pin carries data and the clock pin is an output
  assign scl_rise = i2c_mode & scl_q[1] & ~scl_d;
  assign scl_fall = i2c_mode & ~scl_q[1] & scl_d;
  assign bus_start = i2c_mode & scl_q[1] & scl_d & sda_d & ~sda_q[1];
  assign bus_stop = i2c_mode & scl_q[1] & scl_d & ~sda_d & sda_q[1];

  // Open-drain pins: the data pin only ever pulls low
  assign tx_data_input_out = 1'b0;
  assign tx_data_input_oe = sda_drive;
  assign clock_output_pin_out = preset_clk;
  assign clock_output_pin_oe = ~i2c_mode;

  // Read-back mux; the data port reads as zero, status shows live state
  always_comb begin
    rd_val = 8'h00;
    case (reg_ptr)
      MOD_CFG_ADDR: rd_val[MOD_SEL_BIT] = modulation_select;
      POST_DIV_ADDR: rd_val[POST_W-1:0] = post_div;
      PRE_DIV_ADDR: rd_val = pre_div;
      PA_LEVEL_ADDR: rd_val[PA_W-1:0] = amp_power_level;
      CARRIER_A_ADDR: rd_val = carrier_word[23:16];
      CARRIER_B_ADDR: rd_val = carrier_word[15:8];
      CARRIER_C_ADDR: rd_val = carrier_word[7:0];
      FSK_DEV_ADDR: rd_val[DEV_W-1:0] = fsk_offset_field;
      TX_STATUS_ADDR: begin
        rd_val[STAT_ACTIVE_BIT] = tx_active;
        rd_val[STAT_UNDERFLOW_BIT] = underflow;
        rd_val[STAT_EMPTY_BIT] = ~pop_if.valid;
        rd_val[STAT_FULL_BIT] = ~push_if.ready;
      end
      default: rd_val = 8'h00;
    endcase
  end

  // Serial bus slave: bits sampled on clock rise, data changed on fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= st_idle;
      bit_cnt <= '0;
      rx_shift <= '0;
      tx_shift <= '0;
      reg_ptr <= '0;
      sda_drive <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_en <= 1'b0;
      if (!i2c_mode || bus_stop) begin
        state <= st_idle;
        sda_drive <= 1'b0;
      end else if (bus_start) begin
        state <= st_addr;
        bit_cnt <= '1; // Absorbs the clock fall that follows a start
        sda_drive <= 1'b0;
      end else if (scl_rise && state != st_idle) begin
        if (bit_cnt < ACK_SLOT) begin
          rx_shift <= {rx_shift[6:0], sda_q[1]};
        end else if (state == st_read && sda_q[1]) begin
          state <= st_idle; // Controller declined further bytes
        end
      end else if (scl_fall && state != st_idle) begin
        if (bit_cnt == LAST_BIT) begin
          bit_cnt <= ACK_SLOT;
          sda_drive <= 1'b0;
          case (state)
            st_addr: begin
              if (rx_shift[7:1] == DEVICE_ADDR) begin
                sda_drive <= 1'b1;
                state <= rx_shift[0] ? st_read : st_pointer;
              end else begin
                state <= st_idle;
              end
            end
            st_pointer: begin
              reg_ptr <= rx_shift;
              sda_drive <= 1'b1;
              state <= st_write;
            end
            st_write: begin
              // A full buffer refuses the byte with a not-acknowledge
              if (reg_ptr != TX_DATA_ADDR || push_if.ready) begin
                wr_en <= 1'b1;
                wr_addr <= reg_ptr;
                wr_data <= rx_shift;
                reg_ptr <= reg_ptr + 8'h01;
                sda_drive <= 1'b1;
              end
            end
            st_read: sda_drive <= 1'b0;
            default: state <= st_idle;
          endcase
        end else if (bit_cnt == ACK_SLOT) begin
          bit_cnt <= '0;
          if (state == st_read) begin
            sda_drive <= ~rd_val[7];
            tx_shift <= {rd_val[6:0], 1'b1};
            reg_ptr <= reg_ptr + 8'h01;
          end else begin
            sda_drive <= 1'b0;
          end
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
          if (state == st_read) begin
            sda_drive <= ~tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b1};
          end
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modulation_select <= MOD_RESET;
      post_div <= POST_RESET;
      pre_div <= PRE_RESET;
      amp_power_level <= PA_RESET;
      carrier_word <= CARRIER_RESET;
      fsk_offset_field <= DEV_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        MOD_CFG_ADDR: modulation_select <= wr_data[MOD_SEL_BIT];
        POST_DIV_ADDR: post_div <= wr_data[POST_W-1:0];
        PRE_DIV_ADDR: pre_div <= wr_data;
        PA_LEVEL_ADDR: amp_power_level <= wr_data[PA_W-1:0];
        CARRIER_A_ADDR: carrier_word[23:16] <= wr_data;
        CARRIER_B_ADDR: carrier_word[15:8] <= wr_data;
        CARRIER_C_ADDR: carrier_word[7:0] <= wr_data;
        FSK_DEV_ADDR: fsk_offset_field <= wr_data[DEV_W-1:0];
        default: ;
      endcase
    end
  end

  // Bytes written to the data port feed the buffer
  assign push_if.valid = wr_en && (wr_addr == TX_DATA_ADDR);
  assign push_if.data = wr_data;

  // Out-of-range divider codes are clamped so the rate stays defined
  assign eff_post = (post_div < POST_MIN) ? POST_MIN :
                    (post_div > POST_MAX) ? POST_MAX : post_div;
  assign eff_pre = (pre_div < PRE_MIN) ? PRE_MIN : pre_div;
  assign post_last = 7'((8'h01 << (eff_post + 3'h1)) - 8'h01);
  assign div_reload = wr_en &&
    (wr_addr == POST_DIV_ADDR || wr_addr == PRE_DIV_ADDR);

  // Crystal-rate tick from the system clock by a fractional accumulator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xtal_acc <= '0;
      xtal_tick <= 1'b0;
    end else if (xtal_acc + ACC_STEP >= ACC_WRAP) begin
      xtal_acc <= xtal_acc + ACC_STEP - ACC_WRAP;
      xtal_tick <= 1'b1;
    end else begin
      xtal_acc <= xtal_acc + ACC_STEP;
      xtal_tick <= 1'b0;
    end
  end

  // Fixed crystal divider gives the divider clock tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xdiv_cnt <= '0;
      bclk_tick <= 1'b0;
    end else begin
      bclk_tick <= 1'b0;
      if (xtal_tick) begin
        if (xdiv_cnt == XDIV_LAST) begin
          xdiv_cnt <= '0;
          bclk_tick <= 1'b1;
        end else begin
          xdiv_cnt <= xdiv_cnt + 4'h1;
        end
      end
    end
  end

  // Pre then post divider; a rewrite restarts the interval from zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt <= '0;
      post_cnt <= '0;
      baud_strobe <= 1'b0;
    end else if (div_reload) begin
      pre_cnt <= '0;
      post_cnt <= '0;
      baud_strobe <= 1'b0;
    end else begin
      baud_strobe <= 1'b0;
      if (bclk_tick) begin
        if (pre_cnt == eff_pre) begin
          pre_cnt <= '0;
          if (post_cnt == post_last) begin
            post_cnt <= '0;
            baud_strobe <= 1'b1;
          end else begin
            post_cnt <= post_cnt + 7'h01;
          end
        end else begin
          pre_cnt <= pre_cnt + 8'h01;
        end
      end
    end
  end

  // Preset-mode clock on the clock pin, held low in bus mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      half_cnt <= '0;
      preset_clk <= 1'b0;
    end else if (i2c_mode) begin
      half_cnt <= '0;
      preset_clk <= 1'b0;
    end else if (half_cnt == HALF_LAST) begin
      half_cnt <= '0;
      preset_clk <= ~preset_clk;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  // Bus-mode transmitter: MSB first, one bit per baud strobe
  assign pop_if.ready = i2c_mode && baud_strobe && (bits_left <= 4'h1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_active <= 1'b0;
      underflow <= 1'b0;
      bits_left <= '0;
      tx_byte <= '0;
    end else begin
      // Clear first so an underflow in the same cycle still sets
      if (wr_en && wr_addr == TX_STATUS_ADDR && wr_data[STAT_UNDERFLOW_BIT])
        underflow <= 1'b0;
      if (!i2c_mode) begin
        tx_active <= 1'b0;
        bits_left <= '0;
      end else if (baud_strobe) begin
        if (bits_left > 4'h1) begin
          tx_byte <= {tx_byte[6:0], 1'b0};
          bits_left <= bits_left - 4'h1;
        end else if (pop_if.valid) begin
          tx_byte <= pop_if.data;
          bits_left <= BYTE_BITS;
          tx_active <= 1'b1;
        end else begin
          bits_left <= '0;
          if (tx_active) begin
            tx_active <= 1'b0;
            underflow <= 1'b1;
          end
        end
      end
    end
  end

  // Preset mode takes the pin stream as is; it was held low at power-up
  assign sym_bit = i2c_mode ? tx_byte[7] : sda_q[1];
  assign mark_word = carrier_word +
    (CARRIER_W'(fsk_offset_field) << DEV_SHIFT);

  // Modulator outputs: FSK mark adds the deviation to the carrier
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_enable <= 1'b0;
      tx_symbol <= 1'b0;
      synth_word <= CARRIER_RESET;
    end else begin
      tx_enable <= i2c_mode ? tx_active : 1'b1;
      tx_symbol <= sym_bit;
      synth_word <= (modulation_select == MOD_FSK && sym_bit) ?
                    mark_word : carrier_word;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [15:0] chk_gap;
  logic chk_clean;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chk_gap <= '0;
      chk_clean <= 1'b0;
    end else if (div_reload) begin
      chk_gap <= '0;
      chk_clean <= 1'b0;
    end else if (baud_strobe) begin
      chk_gap <= '0;
      chk_clean <= 1'b1;
    end else if (bclk_tick) begin
      chk_gap <= chk_gap + 16'h0001;
    end
  end

  sequence s_mod_write;
    wr_en && wr_addr == MOD_CFG_ADDR;
  endsequence
  sequence s_last_bit_starved;
    i2c_mode && tx_active && baud_strobe && bits_left <= 4'h1 &&
      !pop_if.valid;
  endsequence

  property p_mode_from_pins;
    $past(rstn, 3) |-> i2c_mode == (!$past(preset_select_low, 3) &&
      !$past(preset_select_high, 3));
  endproperty
  a_mode_from_pins: assert property (p_mode_from_pins)
    else $error("bus mode does not follow select pins");

  property p_bus_pin_roles;
    i2c_mode && $past(i2c_mode) |-> !clock_output_pin_oe && !preset_clk;
  endproperty
  a_bus_pin_roles: assert property (p_bus_pin_roles)
    else $error("clock pin driven in bus mode");

  property p_preset_pins;
    !i2c_mode |-> clock_output_pin_oe && !tx_data_input_oe;
  endproperty
  a_preset_pins: assert property (p_preset_pins)
    else $error("pin roles wrong in preset mode");

  property p_preset_half_period;
    (!i2c_mode && $changed(preset_clk)) ##1 !i2c_mode [*8] |->
      $stable(preset_clk);
  endproperty
  a_preset_half_period: assert property (p_preset_half_period)
    else $error("preset clock toggles too fast");

  property p_pa_reset;
    !$past(rstn) |-> amp_power_level == PA_RESET;
  endproperty
  a_pa_reset: assert property (p_pa_reset)
    else $error("amplifier level not lowest after reset");

  property p_mod_write;
    s_mod_write |=> modulation_select == $past(wr_data[MOD_SEL_BIT]);
  endproperty
  a_mod_write: assert property (p_mod_write)
    else $error("modulation bit did not take write");

  property p_fsk_mark;
    (modulation_select == MOD_FSK && sym_bit) |=>
      synth_word == $past(carrier_word) +
        (CARRIER_W'($past(fsk_offset_field)) << DEV_SHIFT);
  endproperty
  a_fsk_mark: assert property (p_fsk_mark)
    else $error("mark frequency word wrong");

  property p_baud_period;
    (baud_strobe && chk_clean) |->
      chk_gap == 16'((16'(eff_pre) + 16'h0001) * (16'(post_last) + 16'h0001));
  endproperty
  a_baud_period: assert property (p_baud_period)
    else $error("baud interval length wrong");

  property p_underflow_exit;
    s_last_bit_starved |=> !tx_active && underflow;
  endproperty
  a_underflow_exit: assert property (p_underflow_exit)
    else $error("transmission kept after buffer ran dry");

  property p_pre_clamped;
    eff_pre >= PRE_MIN && eff_post >= POST_MIN && eff_post <= POST_MAX &&
      (eff_pre == pre_div || pre_div < PRE_MIN);
  endproperty
  a_pre_clamped: assert property (p_pre_clamped)
    else $error("divider field outside legal range");

endmodule : tx_config_regs_baud_divider

// ---- sim/i2c_host.sv ----
// Behavioural serial bus controller standing in for the host
module i2c_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released lines float high through the pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic hold(input int c);
    repeat (c) @(negedge clk);
  endtask : hold
  // Start (st=1) or stop (st=0); data is set up while the clock is low, then moves while the clock is high
  task automatic cond(input logic st);
    hold(3);
    sda_low = ~st;
    hold(9);
    scl_low = 1'b0;
    hold(9);
    sda_low = st;
    hold(9);
    scl_low = st;
  endtask : cond
  // Nine clocks a phase keeps clear of the eight clock minimum
  task automatic bit_slot(input logic b, output logic seen);
    hold(3);
    sda_low = ~b;
    hold(9);
    scl_low = 1'b0;
    hold(9);
    seen = sda;
    scl_low = 1'b1;
  endtask : bit_slot
  // Byte MSB first, then the ack slot; last=1 leaves the slot free
  task automatic xfer(input logic [7:0] tx, input logic last,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(tx[i], s);
      rx[i] = s;
    end
    bit_slot(last, s);
    ack = ~s;
  endtask : xfer
endmodule : i2c_host

// ---- sim/tx_config_regs_baud_divider_tb.sv ----
// Self-checking bench for the transmitter configuration block
module tx_config_regs_baud_divider_tb
  import tx_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] BUS_ADDR = 7'h2a; // Arbitrary bus address
  logic clk, rstn, sel_lo, sel_hi, sda_low, scl_low, pre_low, sda, scl, ack;
  logic d_oe, d_out, c_out, c_oe, i2c_mode, mod_sel, tx_en, sym, stb;
  logic [1:0] code;
  logic [2:0] pa;
  logic [23:0] carrier, synth;
  logic [6:0] dev;
  logic [7:0] v;
  int failures, comparisons, n;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} row_s;
  row_s rows [9] = '{'{8'h00, 8'h01, 8'h01}, '{8'h06, 8'h07, 8'h07},
    '{8'h0b, 8'h12, 8'h12}, '{8'h0c, 8'h34, 8'h34}, '{8'h0d, 8'h56, 8'h56},
    '{8'h0e, 8'h05, 8'h05}, '{8'h01, 8'h00, 8'h00}, '{8'h02, 8'h00, 8'h00},
    '{8'h05, 8'hab, 8'h00}};
  // Open-drain wires: any party pulling low wins
  assign sda = ~(sda_low | d_oe | pre_low);
  assign scl = ~(scl_low | (c_oe & ~c_out));
  i2c_host u_host (.clk(clk), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));
  tx_config_regs_baud_divider #(.DEVICE_ADDR(BUS_ADDR)) u_dut (
    .clk(clk), .rstn(rstn), .tx_data_input_in(sda),
    .tx_data_input_out(d_out), .tx_data_input_oe(d_oe),
    .clock_output_pin_in(scl), .clock_output_pin_out(c_out),
    .clock_output_pin_oe(c_oe), .preset_select_low(sel_lo),
    .preset_select_high(sel_hi), .i2c_mode(i2c_mode), .preset_code(code),
    .modulation_select(mod_sel), .amp_power_level(pa),
    .carrier_word(carrier), .fsk_offset_field(dev), .tx_enable(tx_en),
    .tx_symbol(sym), .synth_word(synth), .baud_strobe(stb));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic k;
    u_host.cond(1'b1);
    u_host.xfer({BUS_ADDR, 1'b0}, 1'b1, x, k);
    check("address ack", 1, k);
    u_host.xfer(a, 1'b1, x, k);
    u_host.xfer(d, 1'b1, x, ack);
    u_host.cond(1'b0);
  endtask : wr
  // Pointer write, repeated start, one byte read and refused
  task automatic rd(input logic [7:0] a);
    logic k;
    u_host.cond(1'b1);
    u_host.xfer({BUS_ADDR, 1'b0}, 1'b1, v, k);
    u_host.xfer(a, 1'b1, v, k);
    u_host.cond(1'b1);
    u_host.xfer({BUS_ADDR, 1'b1}, 1'b1, v, k);
    u_host.xfer(8'hff, 1'b1, v, k);
    u_host.cond(1'b0);
  endtask : rd
  // Counts clocks up to the next strobe; a stuck divider ends the run
  task automatic gap();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (stb !== 1'b1 && n < 6000);
    if (n >= 6000) begin
      failures++;
      report_and_stop();
    end
  endtask : gap
  initial begin
    failures = 0;
    comparisons = 0;
    rstn = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    pre_low = 1'b1;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    pre_low = 1'b0;
    repeat (6) @(negedge clk);
    check("data pin level", 0, d_out);
    check("amp level", 3'h0, pa);
    check("bus mode", 1, i2c_mode);
    check("clock pin drive", 0, c_oe);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check("readback", rows[i].r, v);
    end
    check("modulation", MOD_FSK, mod_sel);
    check("amp level", 3'h7, pa);
    check("carrier", 24'h123456, carrier);
    check("deviation", 7'h05, dev);
    // Zero divider fields fall back to the fastest legal rate
    gap();
    gap();
    check("baud clamped", 1000, n);
    wr(8'h01, 8'h02);
    wr(8'h02, 8'h04);
    gap();
    gap();
    check("baud period", 2500, n);
    wr(8'h01, 8'h01);
    wr(8'h02, 8'h03);
    // Fill the buffer until a byte is refused
    n = 0;
    ack = 1'b1;
    while (ack === 1'b1 && n < 16) begin
      wr(8'h10, 8'ha5 ^ n[7:0]);
      n++;
    end
    check("refused when full", 0, ack);
    check("bytes taken", 1, n >= 9 && n <= 10);
    // Drain; mark adds the deviation scaled from 1/8192 to 1/65536 steps
    for (int b = 0; b < 100 && tx_en === 1'b1; b++) begin
      gap();
      repeat (4) @(negedge clk);
      if (tx_en === 1'b1)
        check("synth", sym === 1'b1 ? 24'h12347e : 24'h123456, synth);
    end
    check("transmit ended", 0, tx_en);
    rd(8'h11);
    check("underflow flag", 1, v[1]);
    // Preset mode: one select pin released from ground
    sel_lo = 1'b1;
    repeat (8) @(negedge clk);
    check("bus mode", 0, i2c_mode);
    check("clock pin drive", 1, c_oe);
    check("preset code", 2'b01, code);
    check("preset enable", 1, tx_en);
    check("preset symbol", 1, sym);
    for (int i = 0; i < 2; i++) begin
      v[0] = c_out;
      for (n = 0; n < 300 && c_out === v[0]; n++)
        @(negedge clk);
      pre_low = i[0];
    end
    check("clock half period", 125, n);
    // The pin level reaches the symbol through two sync flops and a register
    repeat (4) @(negedge clk);
    check("preset symbol", 0, sym);
    check("preset space", 24'h123456, synth);
    report_and_stop();
  end
endmodule : tx_config_regs_baud_divider_tb
